// ==== hw/fpec_map.svh ====
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
// ==========================================
// Register byte offsets (word aligned except GATE at 1)
`define FPEC_OFS_MODE 4'h0
`define FPEC_OFS_STAT 4'h4
`define FPEC_OFS_PWR 4'h8
`define FPEC_OFS_EBSEL 4'hC
`define FPEC_OFS_GATE 4'h1
// ==========================================
// Mode control fields
`define FPEC_BIT_WREN 6
`define FPEC_BIT_ESETUP 5
`define FPEC_BIT_PSETUP 4
`define FPEC_BIT_EVERIFY 3
`define FPEC_BIT_PVERIFY 2
`define FPEC_BIT_ERASE 1
`define FPEC_BIT_PROG 0
// ==========================================
// Single-bit fields, reset value and mode mask
`define FPEC_BIT_ERRFLAG 7
`define FPEC_BIT_PDDIS 7
`define FPEC_BIT_ACCEN 7
`define FPEC_RST_BYTE 8'h00
`define FPEC_MODE_MASK 8'h7F
`endif

// ==== hw/fpec_pkg.sv ====
package fpec_pkg;
  typedef enum logic [1:0] {
    FPEC_IDLE = 2'b01,
    FPEC_ACK = 2'b10
  } fpec_bus_t;
endpackage

// ==== hw/fpec_blkmap.sv ====
`timescale 1ns/1ps
// ==========================================
// Erase address to one-hot block window decode
module fpec_blkmap (
  input wire logic [15:0] addr_i,
  output logic [7:0] onehot_o
);
  always_comb begin
    onehot_o = 8'h00;
    if (addr_i < 16'h0400) onehot_o[0] = 1'b1;
    else if (addr_i < 16'h0800) onehot_o[1] = 1'b1;
    else if (addr_i < 16'h0C00) onehot_o[2] = 1'b1;
    else if (addr_i < 16'h1000) onehot_o[3] = 1'b1;
    else if (addr_i < 16'h8000) onehot_o[4] = 1'b1;
    else if (addr_i < 16'hC000) onehot_o[5] = 1'b1;
    else if (addr_i < 16'hE000) onehot_o[6] = 1'b1;
    else if (addr_i < 16'hF000) onehot_o[7] = 1'b1;
  end
endmodule // fpec_blkmap

// ==== hw/fpec_top.sv ====
`timescale 1ns/1ps
`include "fpec_map.svh"
// What this block does
// - Program-setup bit enters program setup state; clear cancels; resets zero.
// - Erase-verify bit enters and cancels erase-verify mode.
// - Program-verify bit enters and cancels program-verify mode.
// - Erase mode when erase bit set with write enable and erase setup.
// - Program mode when program bit set with write enable and program setup.
// - Error flag set on program or erase error; zero after reset.
// - Reserved bits read zero and ignore writes.
// - Erase block select held zero while write enable is zero.
// - Write leaving several select bits set clears whole register.
// - Only the selected block may be erased.
// - Select bits map to fixed address windows.
// - Subactive entry powers flash down unless power-down disable set.
// - Access-enable bit gates access to control registers.
// - Write enable zero blocks other mode bits and select bits.
// - Erase-setup bit enters erase setup; set before erase bit.
// - Registers are 8 bits; byte access only.
module fpec_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic err_event_i,
  input wire logic subactive_i,
  input wire logic [15:0] erase_addr_i,
  output logic prog_setup_o,
  output logic erase_setup_o,
  output logic prog_mode_o,
  output logic erase_mode_o,
  output logic prog_verify_o,
  output logic erase_verify_o,
  output logic erase_allowed_o,
  output logic powerdown_o
);
  // ==========================================
  // State
  typedef struct packed {
    fpec_pkg::fpec_bus_t bus;
    logic [7:0] mode;
    logic err_flag;
    logic pd_disable;
    logic accen;
    logic [7:0] ebsel;
    logic [31:0] rdata;
    logic pdown;
  } fpec_state_t;

  fpec_state_t st, next_st;
  logic [7:0] blk_hit;
  logic req, wr, byte0, gated;
  logic [7:0] wb;

  fpec_blkmap u_map (
    .addr_i(erase_addr_i),
    .onehot_o(blk_hit)
  );

  // Gate register lives outside the gated group so it is always reachable
  function automatic logic is_gated(input logic [3:0] a);
    is_gated = (a == `FPEC_OFS_MODE) || (a == `FPEC_OFS_STAT) ||
               (a == `FPEC_OFS_PWR) || (a == `FPEC_OFS_EBSEL);
  endfunction

  assign req = cyc_i && stb_i && (st.bus == fpec_pkg::FPEC_IDLE);
  assign byte0 = sel_i[0];
  assign wr = req && we_i && byte0;
  assign wb = dat_i[7:0];
  assign gated = is_gated(adr_i) && !st.accen;

  always_comb begin
    next_st = st;
    next_st.bus = fpec_pkg::FPEC_IDLE;
    if (req) begin
      next_st.bus = fpec_pkg::FPEC_ACK;
      next_st.rdata = 32'h0000_0000;
      if (!we_i && !gated) begin
        unique case (adr_i)
          `FPEC_OFS_MODE: next_st.rdata = {24'h00_0000, st.mode};
          `FPEC_OFS_STAT: next_st.rdata = {24'h00_0000, st.err_flag, 7'h00};
          `FPEC_OFS_PWR: next_st.rdata = {24'h00_0000, st.pd_disable, 7'h00};
          `FPEC_OFS_EBSEL: next_st.rdata = {24'h00_0000, st.ebsel};
          `FPEC_OFS_GATE: next_st.rdata = {24'h00_0000, st.accen, 7'h00};
          default: next_st.rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr && !gated) begin
      unique case (adr_i)
        `FPEC_OFS_MODE: begin
          if (wb[`FPEC_BIT_WREN]) next_st.mode = wb & `FPEC_MODE_MASK;
          else next_st.mode = `FPEC_RST_BYTE;
        end
        `FPEC_OFS_PWR: next_st.pd_disable = wb[`FPEC_BIT_PDDIS];
        `FPEC_OFS_EBSEL: begin
          if (!st.mode[`FPEC_BIT_WREN]) next_st.ebsel = `FPEC_RST_BYTE;
          else if ($countones(wb) > 1) next_st.ebsel = `FPEC_RST_BYTE;
          else next_st.ebsel = wb;
        end
        `FPEC_OFS_GATE: next_st.accen = wb[`FPEC_BIT_ACCEN];
        default: next_st.mode = next_st.mode; // Status and unmapped: no effect
      endcase
    end
    if (!next_st.mode[`FPEC_BIT_WREN]) next_st.ebsel = `FPEC_RST_BYTE;
    // Sticky until reset; no software clear path exists
    if (err_event_i && (st.mode[`FPEC_BIT_PROG] || st.mode[`FPEC_BIT_ERASE]))
      next_st.err_flag = 1'b1;
    next_st.pdown = subactive_i && !st.pd_disable;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.bus <= fpec_pkg::FPEC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs
  assign ack_o = (st.bus == fpec_pkg::FPEC_ACK);
  assign dat_o = st.rdata;
  assign prog_setup_o = st.mode[`FPEC_BIT_PSETUP];
  assign erase_setup_o = st.mode[`FPEC_BIT_ESETUP];
  assign prog_verify_o = st.mode[`FPEC_BIT_PVERIFY];
  assign erase_verify_o = st.mode[`FPEC_BIT_EVERIFY];
  assign prog_mode_o = st.mode[`FPEC_BIT_PROG] && st.mode[`FPEC_BIT_WREN] &&
                       st.mode[`FPEC_BIT_PSETUP];
  assign erase_mode_o = st.mode[`FPEC_BIT_ERASE] && st.mode[`FPEC_BIT_WREN] &&
                        st.mode[`FPEC_BIT_ESETUP];
  assign erase_allowed_o = erase_mode_o && |(st.ebsel & blk_hit);
  assign powerdown_o = st.pdown;

  // ==========================================
  // Checks
  chk_ebsel_swe: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.mode[`FPEC_BIT_WREN] |-> st.ebsel == 8'h00) else $error("select not cleared");
  chk_ebsel_onehot: assert property (@(posedge clk_i) disable iff (rst_i)
    $countones(st.ebsel) <= 1) else $error("select not one-hot");
  chk_erase_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_mode_o |-> st.mode[`FPEC_BIT_ESETUP]) else $error("erase without setup");
  chk_prog_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    prog_mode_o |-> st.mode[`FPEC_BIT_PSETUP]) else $error("program without setup");
  chk_gate_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && gated) |=> $stable({st.mode, st.pd_disable, st.ebsel}))
    else $error("gated write took");
  chk_flash_error_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    st.err_flag |=> st.err_flag) else $error("error flag lost");
  chk_pdown: assert property (@(posedge clk_i) disable iff (rst_i)
    (subactive_i && !st.pd_disable) |=> powerdown_o) else $error("no power-down");
  chk_erase_blk: assert property (@(posedge clk_i) disable iff (rst_i)
    erase_allowed_o |-> (st.ebsel & blk_hit) != 8'h00) else $error("wrong block");
  chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack too long");
  cov_prog: cover property (@(posedge clk_i) prog_mode_o);
  cov_erase: cover property (@(posedge clk_i) erase_allowed_o);
  cov_flash_error_flag: cover property (@(posedge clk_i) st.err_flag);
endmodule // fpec_top

// ==== tb/fpec_top_tb.sv ====
`timescale 1ns/1ps
module fpec_top_tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, err_event_i = 0, subactive_i = 0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0000_0000, dat_o;
  logic [15:0] erase_addr_i = 16'h0000;
  logic ack_o, prog_setup_o, erase_setup_o, prog_mode_o, erase_mode_o;
  logic prog_verify_o, erase_verify_o, erase_allowed_o, powerdown_o;
  int num_errors = 0, comparisons = 0, seed = 64;
  int md = 0, eb = 0, pw = 0, gt = 0, fl = 0, pm, em;
  // Step table: high digit is the offset, offset F pulses an array error
  // One new mode bit per write, one select write with two bits set, status never written
  logic [11:0] steps [17] = '{12'h040, 12'hC03, 12'hC80, 12'h060, 12'h062, 12'h880, 12'h060,
    12'h040, 12'h050, 12'h051, 12'hF00, 12'h050, 12'h044, 12'h040, 12'h048, 12'h800, 12'h000};
  fpec_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_event_i(err_event_i), .subactive_i(subactive_i), .erase_addr_i(erase_addr_i),
    .prog_setup_o(prog_setup_o), .erase_setup_o(erase_setup_o), .prog_mode_o(prog_mode_o),
    .erase_mode_o(erase_mode_o), .prog_verify_o(prog_verify_o),
    .erase_verify_o(erase_verify_o), .erase_allowed_o(erase_allowed_o),
    .powerdown_o(powerdown_o));
  always #20 clk_i = ~clk_i;
  // ==========================================
  // Bus and compare helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h00_0000, d};
    do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n == 50) num_errors++;
    cyc_i <= 0; stb_i <= 0;
    @(posedge clk_i);
  endtask
  function automatic int blk(input int a);
    return a < 16'h1000 ? 1 << (a >> 10) : a < 16'h8000 ? 8'h10 : a < 16'hC000 ? 8'h20 :
      a < 16'hE000 ? 8'h40 : a < 16'hF000 ? 8'h80 : 8'h00;
  endfunction
  task wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1, a, d, q);
    if (a == 4'h1) gt = d & 8'h80;
    if (gt != 0 && a == 4'h0) md = d[6] ? d & 8'h7F : 0;
    if (gt != 0 && a == 4'h8) pw = d & 8'h80;
    if (gt != 0 && a == 4'hC && md[6]) eb = $countones(d) > 1 ? 0 : d;
    if (!md[6]) eb = 0;
  endtask
  task chk;
    logic [31:0] q;
    pm = md[0] & md[6] & md[4];
    em = md[1] & md[6] & md[5];
    erase_addr_i <= {3'h7, 13'($random(seed))};
    wb(0, 4'h1, 8'h00, q); check(q, gt);
    wb(0, 4'h0, 8'h00, q); check(q, gt ? md : 0);
    wb(0, 4'h4, 8'h00, q); check(q, gt ? fl : 0);
    wb(0, 4'h8, 8'h00, q); check(q, gt ? pw : 0);
    wb(0, 4'hC, 8'h00, q); check(q, gt ? eb : 0);
    wb(0, 4'h2, 8'h00, q); check(q, 0);
    check({prog_setup_o, erase_setup_o, prog_verify_o, erase_verify_o},
      {md[4], md[5], md[2], md[3]});
    check({prog_mode_o, erase_mode_o}, {pm[0], em[0]});
    check(erase_allowed_o, em && (blk(erase_addr_i) & eb) != 0);
    check(powerdown_o, subactive_i && pw == 0);
  endtask
  task finish_test;
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================
  // Main sequence, gate closed first, then each step
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk;
    wr(4'h0, 8'h40); wr(4'h8, 8'h80); wr(4'hC, 8'h01);
    subactive_i <= 1;
    chk;
    wr(4'h1, 8'hFF);
    chk;
    foreach (steps[i]) begin
      if (steps[i][11:8] == 4'hF) begin
        err_event_i <= 1;
        @(posedge clk_i);
        err_event_i <= 0;
        if (pm != 0) fl = 8'h80;
      end
      wr(steps[i][11:8], steps[i][7:0]);
      chk;
    end
    finish_test;
  end
  initial begin
    #200000;
    num_errors++;
    finish_test;
  end
endmodule // fpec_top_tb
